// *** rtl/disk_dma_regs.svh ***
// Contract
// - The controller asks for the system bus whenever the FIFO must be refilled or drained to keep up with the disk.
// - Once granted, the controller holds the bus for at most about 8 us per burst and then lets it go.
// - The controller keeps requesting the bus, burst after burst, until the whole transfer is done.
// - At completion the controller raises an interrupt, writes a ready status byte into the command memory, or both.
// - The controller appends a CRC on writes to disk and checks the CRC on reads from disk.
// - A CRC mismatch on a read restarts the transfer automatically without host help, up to 3 times; the next mismatch ends it with an error.
// - The local FIFO holds 16 words (32 bytes) and chains with an 8-word buffer on the drive board, 24 words in all.
// - The request threshold leaves enough headroom that the 1.25 Mbyte/s disk stream never overruns or underruns.
// - Multi-sector transfers run contiguously in short bursts with no full-sector buffer.
// - The DMA address covers the whole 16 Mbyte system memory space.
// - The cable carries device commands and status between the local MCU and the drive board besides the data.
// - The host enters commands in a 128-byte dual-port memory that the local MCU also reaches.
`ifndef DISK_DMA_REGS_SVH
`define DISK_DMA_REGS_SVH

`define CLK_PERIOD_NS    100
`define BURST_TIME_NS    8000
`define BURST_CYCLES     (`BURST_TIME_NS / `CLK_PERIOD_NS)
`define FIFO_WORDS       16
`define LINK_FIFO_WORDS  8
`define REQ_LEVEL        8
`define MAX_RETRY        3
`define ADDR_STEP        24'h000002
`define CMD_MEM_BYTES    128
`define STATUS_BYTE_ADDR 7'h7f
`define STAT_READY_BIT   0
`define STAT_ERROR_BIT   1
`define STAT_RETRY_LSB   4
`define CRC_INIT         16'hffff
`define CRC_POLY         16'h1021

`endif

// *** rtl/disk_dma_pkg.sv ***
package disk_dma_pkg;
    typedef struct packed {
        logic        to_disk;
        logic        irq_en;
        logic        stat_en;
        logic [23:0] addr;
        logic [15:0] words;
    } cmd_s;

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic        write;
    } bus_s;

    typedef struct packed {
        logic       we;
        logic [6:0] addr;
        logic [7:0] wdata;
    } mem_req_s;

    typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_RETRY, ST_DRAIN, ST_DONE} xfer_state_e;
    typedef enum logic [2:0] {BS_IDLE, BS_REQ, BS_OWN, BS_WAIT, BS_RECOVER, BS_RELEASE} bus_state_e;
endpackage : disk_dma_pkg

// *** rtl/disk_word_fifo.sv ***
`timescale 1ns/1ps
module disk_word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic                       ref_clk_in,
    input  wire logic                       arst_n_in,
    input  wire logic                       flush_in,
    // fill side
    input  wire logic                       in_valid_in,
    output logic                            in_ready_out,
    input  wire logic [WIDTH-1:0]           in_data_in,
    // drain side
    output logic                            out_valid_out,
    input  wire logic                       out_ready_in,
    output logic [WIDTH-1:0]                out_data_out,
    output logic [$clog2(DEPTH+1)-1:0]      level_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [LW-1:0] FULL = LW'(DEPTH);

    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_cfg
        $error("fifo needs at least two entries");
    end

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_idx;
    logic [AW-1:0]    rd_idx;
    logic             push;
    logic             pop;

    assign in_ready_out  = level_out != FULL;
    assign out_valid_out = level_out != '0;
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;
    assign out_data_out  = store[rd_idx];

    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            store[wr_idx] <= in_data_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_idx    <= '0;
            rd_idx    <= '0;
            level_out <= '0;
        end else if (flush_in) begin
            wr_idx    <= '0;
            rd_idx    <= '0;
            level_out <= '0;
        end else begin
            if (push) wr_idx <= (wr_idx == LAST) ? '0 : wr_idx + AW'(1);
            if (pop) rd_idx <= (rd_idx == LAST) ? '0 : rd_idx + AW'(1);
            if (push && !pop) level_out <= level_out + LW'(1);
            else if (pop && !push) level_out <= level_out - LW'(1);
        end
    end

    a_fifo_level_up: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        (!flush_in && push && !pop) |=> level_out == $past(level_out) + LW'(1))
        else $error("fifo level did not rise on push");
    a_fifo_level_cap: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        level_out <= FULL && (level_out == FULL) == !in_ready_out)
        else $error("fifo level beyond depth");
endmodule : disk_word_fifo

// *** rtl/crc16_word.sv ***
`timescale 1ns/1ps
`include "disk_dma_regs.svh"
module crc16_word #(
    parameter logic [15:0] POLY = `CRC_POLY,
    parameter logic [15:0] INIT = `CRC_INIT
) (
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        arst_n_in,
    // data words
    input  wire logic        clear_in,
    input  wire logic        en_in,
    input  wire logic [15:0] data_in,
    output logic [15:0]      crc_out
);
    // msb first, one word per cycle
    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [15:0] data);
        logic [15:0] c;
        c = crc;
        for (int i = 15; i >= 0; i--) begin
            c = (c[15] ^ data[i]) ? ((c << 1) ^ POLY) : (c << 1);
        end
        return c;
    endfunction : crc_step

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            crc_out <= INIT;
        end else if (clear_in) begin
            crc_out <= INIT;
        end else if (en_in) begin
            crc_out <= crc_step(crc_out, data_in);
        end
    end

    a_crc_clear_init: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        clear_in |=> crc_out == INIT)
        else $error("crc not reset to init");
    a_crc_idle_hold: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
        (!clear_in && !en_in) |=> $stable(crc_out))
        else $error("crc moved without data");
endmodule : crc16_word

// *** rtl/disk_dma_fifo_controller.sv ***
`timescale 1ns/1ps
`include "disk_dma_regs.svh"
module disk_dma_fifo_controller
    import disk_dma_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_WORDS,
    parameter int REQ_LEVEL  = `REQ_LEVEL,
    parameter int MAX_RETRY  = `MAX_RETRY
) (
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        arst_n_in,
    // local command port
    input  wire logic        cmd_valid_in,
    input  wire cmd_s        cmd_in,
    output logic             cmd_ready_out,
    output logic             done_out,
    output logic             error_out,
    input  wire logic        irq_ack_in,
    output logic             irq_out,
    // system bus master
    output logic             bus_req_out,
    input  wire logic        bus_grant_in,
    output logic             bus_strobe_out,
    output bus_s             bus_out,
    input  wire logic        bus_ack_in,
    input  wire logic [15:0] bus_rdata_in,
    // disk data stream over the cable
    output logic             disk_wvalid_out,
    output logic [15:0]      disk_wdata_out,
    input  wire logic        disk_wready_in,
    input  wire logic        disk_rvalid_in,
    input  wire logic [15:0] disk_rdata_in,
    output logic             disk_rready_out,
    output logic             link_retry_out,
    // device command and status over the cable
    input  wire logic        mcu_link_valid_in,
    input  wire logic [7:0]  mcu_link_cmd_in,
    output logic             link_cmd_valid_out,
    output logic [7:0]       link_cmd_out,
    input  wire logic        link_stat_valid_in,
    input  wire logic [7:0]  link_stat_in,
    output logic             mcu_stat_valid_out,
    output logic [7:0]       mcu_stat_out,
    // shared command memory
    input  wire mem_req_s    host_mem_in,
    output logic [7:0]       host_rdata_out,
    input  wire mem_req_s    mcu_mem_in,
    output logic [7:0]       mcu_rdata_out
);
    localparam int LW        = $clog2(FIFO_DEPTH + 1);
    localparam int BURST_CYC = `BURST_CYCLES;
    localparam logic [7:0]    BURST_LIM = 8'(BURST_CYC);
    localparam logic [LW-1:0] REQ_LVL   = LW'(REQ_LEVEL);
    localparam logic [LW-1:0] ROOM_LVL  = LW'(FIFO_DEPTH - REQ_LEVEL);
    localparam logic [1:0]    RETRY_LIM = 2'(MAX_RETRY);

    if (REQ_LEVEL < 1 || REQ_LEVEL > FIFO_DEPTH || MAX_RETRY > 3 || BURST_CYC < 1 || BURST_CYC > 255)
    begin : g_bad_cfg
        $error("unsupported controller configuration");
    end

    // grant and ack come from the asynchronous bus
    logic [1:0]  pin_s1;
    logic [1:0]  pin_s2;
    logic [1:0]  pin_s3;
    logic [1:0]  pin_q;
    logic        grant_q;
    logic        ack_q;

    xfer_state_e xfer;
    bus_state_e  bus_st;
    cmd_s        cmd;
    cmd_s        src;
    logic [15:0] bus_left;
    logic [15:0] disk_left;
    logic [23:0] cur_addr;
    logic [7:0]  burst_timer;
    logic [1:0]  retries;
    logic        crc_sent;

    logic          f_in_valid;
    logic          f_in_ready;
    logic [15:0]   f_in_data;
    logic          f_out_valid;
    logic          f_out_ready;
    logic [15:0]   f_out_data;
    logic [LW-1:0] f_level;
    logic          crc_en;
    logic [15:0]   crc_data;
    logic [15:0]   crc_val;

    logic        accept;
    logic        retry_go;
    logic        restart;
    logic        active;
    logic        need_bus;
    logic        can_cycle;
    logic        bus_start;
    logic        cyc_done;
    logic        disk_free;
    logic        wr_take_data;
    logic        wr_take_crc;
    logic        wr_crc_done;
    logic        rd_take;
    logic        crc_word;
    logic        crc_bad;
    logic        stat_wr;
    logic [7:0]  stat_byte;
    logic [7:0]  cmd_mem [`CMD_MEM_BYTES];

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_s1 <= 2'h0;
            pin_s2 <= 2'h0;
            pin_s3 <= 2'h0;
            pin_q  <= 2'h0;
        end else begin
            pin_s1 <= {bus_ack_in, bus_grant_in};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_q  <= (pin_s2 & pin_s3) | (pin_q & (pin_s2 ^ pin_s3));
        end
    end
    assign grant_q = pin_q[0];
    assign ack_q   = pin_q[1];

    assign accept    = cmd_valid_in && cmd_ready_out;
    assign retry_go  = xfer == ST_RETRY && bus_st == BS_IDLE;
    assign restart   = accept || retry_go;
    assign src       = accept ? cmd_in : cmd;
    assign active    = (xfer == ST_RUN || xfer == ST_DRAIN) && !error_out;
    assign cmd_ready_out = xfer == ST_IDLE;
    assign done_out  = xfer == ST_DONE;

    // request at half fill so the drive-board buffer absorbs bus latency
    assign need_bus  = active && bus_left != 16'h0000 &&
                       (cmd.to_disk ? f_level <= ROOM_LVL
                                    : (f_level >= REQ_LVL || 16'(f_level) >= bus_left));
    assign can_cycle = active && bus_left != 16'h0000 && burst_timer < BURST_LIM &&
                       (cmd.to_disk ? f_in_ready : f_out_valid);
    assign bus_start = bus_st == BS_OWN && can_cycle;
    assign cyc_done  = bus_st == BS_WAIT && ack_q;
    assign bus_req_out    = bus_st == BS_REQ || bus_st == BS_OWN || bus_st == BS_WAIT || bus_st == BS_RECOVER;
    assign bus_strobe_out = bus_st == BS_WAIT;

    // disk write side: data words, then one crc word
    assign disk_free    = !disk_wvalid_out || disk_wready_in;
    assign wr_take_data = cmd.to_disk && xfer == ST_RUN && disk_free && disk_left != 16'h0000 && f_out_valid;
    assign wr_take_crc  = cmd.to_disk && xfer == ST_RUN && disk_free && disk_left == 16'h0000 && !crc_sent;
    assign wr_crc_done  = cmd.to_disk && crc_sent && disk_wvalid_out && disk_wready_in;

    // disk read side: data words, then the recorded crc word
    assign disk_rready_out = !cmd.to_disk && xfer == ST_RUN && (disk_left != 16'h0000 ? f_in_ready : 1'b1);
    assign rd_take  = disk_rready_out && disk_rvalid_in && disk_left != 16'h0000;
    assign crc_word = disk_rready_out && disk_rvalid_in && disk_left == 16'h0000;
    assign crc_bad  = crc_word && disk_rdata_in != crc_val;

    // bus read data is stable long before the synchronised ack is seen
    assign f_in_valid  = cmd.to_disk ? cyc_done : rd_take;
    assign f_in_data   = cmd.to_disk ? bus_rdata_in : disk_rdata_in;
    assign f_out_ready = cmd.to_disk ? wr_take_data : bus_start;
    assign crc_en      = cmd.to_disk ? wr_take_data : rd_take;
    assign crc_data    = cmd.to_disk ? f_out_data : disk_rdata_in;

    disk_word_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in    (ref_clk_in),
        .arst_n_in     (arst_n_in),
        .flush_in      (restart),
        .in_valid_in   (f_in_valid),
        .in_ready_out  (f_in_ready),
        .in_data_in    (f_in_data),
        .out_valid_out (f_out_valid),
        .out_ready_in  (f_out_ready),
        .out_data_out  (f_out_data),
        .level_out     (f_level)
    );

    crc16_word u_crc (
        .ref_clk_in (ref_clk_in),
        .arst_n_in  (arst_n_in),
        .clear_in   (restart),
        .en_in      (crc_en),
        .data_in    (crc_data),
        .crc_out    (crc_val)
    );

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            xfer      <= ST_IDLE;
            cmd       <= '0;
            retries   <= 2'h0;
            error_out <= 1'b0;
        end else begin
            case (xfer)
                ST_IDLE: begin
                    if (accept) begin
                        xfer      <= ST_RUN;
                        cmd       <= cmd_in;
                        retries   <= 2'h0;
                        error_out <= 1'b0;
                    end
                end
                ST_RUN: begin
                    if (crc_bad && retries == RETRY_LIM) begin
                        xfer      <= ST_DRAIN;
                        error_out <= 1'b1;
                    end else if (crc_bad) begin
                        xfer <= ST_RETRY;
                    end else if (crc_word || wr_crc_done) begin
                        xfer <= ST_DRAIN;
                    end
                end
                ST_RETRY: begin
                    if (retry_go) begin
                        xfer    <= ST_RUN;
                        retries <= retries + 2'h1;
                    end
                end
                ST_DRAIN: begin
                    if ((bus_left == 16'h0000 || error_out) && bus_st == BS_IDLE) xfer <= ST_DONE;
                end
                ST_DONE: xfer <= ST_IDLE;
                default: xfer <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bus_left  <= 16'h0000;
            disk_left <= 16'h0000;
            cur_addr  <= 24'h000000;
            crc_sent  <= 1'b0;
        end else if (restart) begin
            bus_left  <= src.words;
            disk_left <= src.words;
            cur_addr  <= src.addr;
            crc_sent  <= 1'b0;
        end else begin
            if (cyc_done) begin
                bus_left <= bus_left - 16'h0001;
                cur_addr <= cur_addr + `ADDR_STEP;
            end
            if (wr_take_data || rd_take) disk_left <= disk_left - 16'h0001;
            if (wr_take_crc) crc_sent <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bus_st      <= BS_IDLE;
            burst_timer <= 8'h00;
        end else begin
            if (bus_st == BS_REQ) burst_timer <= 8'h00;
            else if (bus_req_out && burst_timer != 8'hff) burst_timer <= burst_timer + 8'h01;
            case (bus_st)
                BS_IDLE:    if (need_bus) bus_st <= BS_REQ;
                BS_REQ:     if (grant_q) bus_st <= BS_OWN;
                BS_OWN:     bus_st <= can_cycle ? BS_WAIT : BS_RELEASE;
                BS_WAIT:    if (ack_q) bus_st <= BS_RECOVER;
                BS_RECOVER: if (!ack_q) bus_st <= BS_OWN;
                BS_RELEASE: if (!grant_q) bus_st <= BS_IDLE;
                default:    bus_st <= BS_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bus_out         <= '0;
            disk_wvalid_out <= 1'b0;
            disk_wdata_out  <= 16'h0000;
            irq_out         <= 1'b0;
            link_retry_out  <= 1'b0;
        end else begin
            if (bus_start) begin
                bus_out.addr  <= cur_addr;
                bus_out.wdata <= f_out_data;
                bus_out.write <= !cmd.to_disk;
            end
            if (disk_free) disk_wvalid_out <= wr_take_data || wr_take_crc;
            if (wr_take_data) disk_wdata_out <= f_out_data;
            else if (wr_take_crc) disk_wdata_out <= crc_val;
            // a new completion beats a simultaneous acknowledge
            if (done_out && cmd.irq_en) irq_out <= 1'b1;
            else if (irq_ack_in) irq_out <= 1'b0;
            link_retry_out <= retry_go;
        end
    end

    // device commands and status share the cable with the data
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            link_cmd_valid_out <= 1'b0;
            link_cmd_out       <= 8'h00;
            mcu_stat_valid_out <= 1'b0;
            mcu_stat_out       <= 8'h00;
        end else begin
            link_cmd_valid_out <= mcu_link_valid_in;
            if (mcu_link_valid_in) link_cmd_out <= mcu_link_cmd_in;
            mcu_stat_valid_out <= link_stat_valid_in;
            if (link_stat_valid_in) mcu_stat_out <= link_stat_in;
        end
    end

    assign stat_wr = done_out && cmd.stat_en;
    always_comb begin
        stat_byte = 8'h00;
        stat_byte[`STAT_READY_BIT] = 1'b1;
        stat_byte[`STAT_ERROR_BIT] = error_out;
        stat_byte[`STAT_RETRY_LSB +: 2] = retries;
    end

    // later writes win: ready status over mcu over host
    always_ff @(posedge ref_clk_in) begin
        if (host_mem_in.we) cmd_mem[host_mem_in.addr] <= host_mem_in.wdata;
        if (mcu_mem_in.we) cmd_mem[mcu_mem_in.addr] <= mcu_mem_in.wdata;
        if (stat_wr) cmd_mem[`STATUS_BYTE_ADDR] <= stat_byte;
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            host_rdata_out <= 8'h00;
            mcu_rdata_out  <= 8'h00;
        end else begin
            host_rdata_out <= cmd_mem[host_mem_in.addr];
            mcu_rdata_out  <= cmd_mem[mcu_mem_in.addr];
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);

    a_req_has_work: assert property ($rose(bus_req_out) |-> $past(need_bus))
        else $error("bus requested without fifo demand");
    a_burst_time_cap: assert property ($rose(bus_strobe_out) |-> $past(burst_timer) < BURST_LIM)
        else $error("bus cycle started after burst time");
    a_rerequest_more: assert property ((bus_st == BS_IDLE && need_bus) |=> bus_req_out)
        else $error("pending work without a new request");
    a_irq_on_done: assert property ((done_out && cmd.irq_en) |=> irq_out)
        else $error("completion interrupt missing");
    a_status_ready: assert property (stat_wr |=> cmd_mem[`STATUS_BYTE_ADDR][`STAT_READY_BIT])
        else $error("ready status not written");
    a_crc_tail_word: assert property (wr_take_crc |=> disk_wvalid_out && disk_wdata_out == $past(crc_val))
        else $error("write crc word wrong");
    a_crc_retry_go: assert property ((crc_bad && retries != RETRY_LIM) |=> xfer == ST_RETRY)
        else $error("crc mismatch did not retry");
    a_addr_step_word: assert property (cyc_done |=> cur_addr == $past(cur_addr) + `ADDR_STEP)
        else $error("dma address did not advance");
    a_early_release: assert property ((bus_st == BS_OWN && !can_cycle) |=>
        bus_st == BS_RELEASE ##1 !bus_req_out) else $error("burst not ended early");
    a_link_cmd_pass: assert property (mcu_link_valid_in |=>
        link_cmd_valid_out && link_cmd_out == $past(mcu_link_cmd_in)) else $error("device command not forwarded");

    c_retry_seen: cover property (link_retry_out);
    c_burst_timeout: cover property (bus_st == BS_OWN && burst_timer >= BURST_LIM && bus_left != 16'h0000);
    c_done_irq: cover property (done_out && cmd.irq_en && !error_out);
    c_done_error: cover property (done_out && error_out);
endmodule : disk_dma_fifo_controller

// *** verif/sysbus_mem.sv ***
`timescale 1ns/1ps
module sysbus_mem
    import disk_dma_pkg::*;
(
    input  wire logic   ref_clk_in,
    input  wire logic   req_in,
    input  wire logic   strobe_in,
    input  wire bus_s   bus_in,
    output logic        grant_out,
    output logic        ack_out,
    output logic [15:0] rdata_out
);
    logic [15:0] mem [0:255];
    initial begin
        {grant_out, ack_out, rdata_out} = '0;
        for (int i = 0; i < 256; i++) mem[i] = 16'h1000 + 16'(i);
    end
    // four-phase: ack holds until strobe drops; released data is scrambled
    always @(posedge ref_clk_in) begin
        grant_out <= req_in;
        if (strobe_in && !ack_out) begin
            if (bus_in.write) mem[bus_in.addr[8:1]] <= bus_in.wdata;
            rdata_out <= mem[bus_in.addr[8:1]];
            ack_out <= 1'b1;
        end else if (!strobe_in && ack_out) begin
            ack_out <= 1'b0;
            rdata_out <= ~rdata_out;
        end
    end
endmodule : sysbus_mem

// *** verif/disk_dma_fifo_controller_bench.sv ***
`timescale 1ns/1ps
module disk_dma_fifo_controller_bench;
    import disk_dma_pkg::*;
    logic        ref_clk_in, arst_n_in, cmd_valid_in, irq_ack_in, bus_grant_in, bus_ack_in, disk_wready_in;
    logic        disk_rvalid_in, mcu_link_valid_in, link_stat_valid_in, cmd_ready_out, done_out, error_out;
    logic        irq_out, bus_req_out, bus_strobe_out, disk_wvalid_out, disk_rready_out, link_retry_out;
    logic        link_cmd_valid_out, mcu_stat_valid_out, src_on, bad;
    logic [15:0] bus_rdata_in, disk_rdata_in, disk_wdata_out, crc;
    logic [7:0]  mcu_link_cmd_in, link_stat_in, link_cmd_out, mcu_stat_out, host_rdata_out, mcu_rdata_out;
    cmd_s        cmd_in;
    bus_s        bus_out;
    mem_req_s    host_mem_in, mcu_mem_in;
    int          err_total, n_checks, cyc, idx, nw, burst, bmax, nb, nretry;
    logic [15:0] got[$];
    disk_dma_fifo_controller DUT (.ref_clk_in, .arst_n_in, .cmd_valid_in, .cmd_in, .cmd_ready_out, .done_out,
        .error_out, .irq_ack_in, .irq_out, .bus_req_out, .bus_grant_in, .bus_strobe_out, .bus_out, .bus_ack_in,
        .bus_rdata_in, .disk_wvalid_out, .disk_wdata_out, .disk_wready_in, .disk_rvalid_in, .disk_rdata_in,
        .disk_rready_out, .link_retry_out, .mcu_link_valid_in, .mcu_link_cmd_in, .link_cmd_valid_out,
        .link_cmd_out, .link_stat_valid_in, .link_stat_in, .mcu_stat_valid_out, .mcu_stat_out, .host_mem_in,
        .host_rdata_out, .mcu_mem_in, .mcu_rdata_out);
    sysbus_mem P (.ref_clk_in, .req_in(bus_req_out), .strobe_in(bus_strobe_out), .bus_in(bus_out),
        .grant_out(bus_grant_in), .ack_out(bus_ack_in), .rdata_out(bus_rdata_in));
    function automatic logic [15:0] crc_of(input logic [15:0] c, input logic [15:0] d);
        for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction : crc_of
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic results;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            results();
        end
        if (disk_wvalid_out && disk_wready_in) got.push_back(disk_wdata_out);
        if (disk_rvalid_in && disk_rready_out) idx <= idx + 1;
        if (link_retry_out) idx <= 0;
        if (link_retry_out) nretry++;
        if (bus_req_out && burst == 0) nb++;
        burst <= bus_req_out ? burst + 1 : 0;
        if (burst > bmax) bmax <= burst;
        if (bus_strobe_out) chk(bus_out.addr[23:16], 8'hff);
    end
    // sink stalls every other cycle; source sends words then crc word
    always @(negedge ref_clk_in) begin
        disk_wready_in <= cyc[0];
        disk_rvalid_in <= src_on && idx <= nw;
        disk_rdata_in <= (idx < nw) ? 16'ha500 + 16'(idx) : crc ^ {15'h0, bad};
    end
    task automatic run(input logic td, input logic [15:0] w);
        @(negedge ref_clk_in);
        cmd_in = '{td, 1'b1, 1'b1, 24'hff0040, w};
        cmd_valid_in = 1'b1;
        chk(cmd_ready_out, 1'b1);
        @(negedge ref_clk_in);
        cmd_valid_in = 1'b0;
        chk(cmd_ready_out, 1'b0);
        for (int k = 0; k < 20000 && done_out !== 1'b1; k++) @(negedge ref_clk_in);
        @(negedge ref_clk_in);
        chk(done_out, 1'b0);
        chk(irq_out, 1'b1);
        irq_ack_in = 1'b1;
        @(negedge ref_clk_in);
        irq_ack_in = 1'b0;
        chk(irq_out, 1'b0);
    endtask : run
    task automatic to_disk_test;
        crc = 16'hffff;
        for (int k = 0; k < 40; k++) crc = crc_of(crc, 16'h1020 + 16'(k));
        run(1'b1, 16'd40);
        chk(16'(got.size()), 16'd41);
        for (int k = 0; k < 40; k++) chk(got[k], 16'h1020 + 16'(k));
        chk(got[40], crc);
        chk(host_rdata_out, 8'h01);
        chk(16'(nb > 1), 16'd1);
        chk(16'(bmax <= 100), 16'd1);
    endtask : to_disk_test
    task automatic from_disk_test(input logic b);
        {nw, bad, idx, nretry, src_on} = {32'd24, b, 64'd0, 1'b1};
        crc = 16'hffff;
        for (int k = 0; k < 24; k++) crc = crc_of(crc, 16'ha500 + 16'(k));
        run(1'b0, 16'd24);
        src_on = 1'b0;
        for (int k = 0; k < 24; k++) chk(P.mem[8'h20 + 8'(k)], 16'ha500 + 16'(k));
        chk(error_out, b);
        chk(16'(nretry), b ? 16'd3 : 16'd0);
        chk(host_rdata_out, b ? 8'h33 : 8'h01);
    endtask : from_disk_test
    task automatic link_test;
        mcu_link_valid_in = 1'b1;
        mcu_link_cmd_in = 8'h5a;
        link_stat_valid_in = 1'b1;
        link_stat_in = 8'hc3;
        host_mem_in = '{1'b1, 7'h10, 8'h3c};
        @(negedge ref_clk_in);
        {mcu_link_valid_in, link_stat_valid_in, host_mem_in} = '0;
        chk(link_cmd_valid_out, 1'b1);
        chk(link_cmd_out, 8'h5a);
        chk(mcu_stat_valid_out, 1'b1);
        chk(mcu_stat_out, 8'hc3);
        mcu_mem_in = '{1'b0, 7'h10, 8'h00};
        repeat (2) @(negedge ref_clk_in);
        chk(mcu_rdata_out, 8'h3c);
        chk(link_cmd_valid_out, 1'b0);
        chk(mcu_stat_valid_out, 1'b0);
    endtask : link_test
    initial begin
        {arst_n_in, cmd_valid_in, irq_ack_in, disk_wready_in, disk_rvalid_in, cmd_in, disk_rdata_in} = '0;
        {mcu_link_valid_in, link_stat_valid_in, mcu_link_cmd_in, link_stat_in, mcu_mem_in} = '0;
        {err_total, n_checks, cyc, idx, nw, burst, bmax, nb, nretry, src_on, bad, crc} = '0;
        host_mem_in = '{1'b0, 7'h7f, 8'h00};
        repeat (10) @(negedge ref_clk_in);
        arst_n_in = 1'b1;
        to_disk_test();
        from_disk_test(1'b0);
        from_disk_test(1'b1);
        link_test();
        results();
    end
endmodule : disk_dma_fifo_controller_bench
